// ===== core/pfs_regs.svh
`ifndef PFS_REGS_SVH
`define PFS_REGS_SVH
// Clock and soft-start timing
`define PFS_CLK_MHZ        200
`define PFS_SS_STEP_NS     1000
`define PFS_SS_STEP_CYC    ((`PFS_SS_STEP_NS * `PFS_CLK_MHZ) / 1000)
// Soft-start node levels, 32 steps per volt
`define PFS_SS_ZERO_LVL    8'h00
`define PFS_SS_FAST_LVL    8'h20
`define PFS_SS_FULL_LVL    8'h80
`define PFS_SS_VALLEY_LVL  8'h28
// Over-current retries and inhibit code
`define PFS_OC_LIMIT       2'h3
`define PFS_INHIBIT_CODE   5'h1f
// Register map and fields
`define PFS_ADDR_MASK      12'hffc
`define PFS_STATUS_OFF     12'h000
`define PFS_CONTROL_OFF    12'h004
`define PFS_CONTROL_RST    32'h0000_0000
`define PFS_CTRL_SHDN_BIT  0
`define PFS_RESP_OKAY      2'h0
`define PFS_RESP_SLVERR    2'h2
`endif

// ===== core/pfs_pkg.sv
package pfs_pkg;
  // Sequencer states; code 3'b111 is illegal
  typedef enum logic [2:0] {
    PFS_OFF       = 3'b000,
    PFS_FAST      = 3'b001,
    PFS_CHARGE    = 3'b010,
    PFS_RUN       = 3'b011,
    PFS_OC_CHARGE = 3'b100,
    PFS_DISCHARGE = 3'b101,
    PFS_FAULT     = 3'b110
  } pfs_state_type;
endpackage : pfs_pkg

// ===== core/pfs_power_fault_sequencer.sv
// Notes on behaviour
// - Soft-start waits until bias and 5 V monitors both pass power-on-reset.
// - Soft-start node jumps to 1 V, then charges slowly to 4 V.
// - During soft-start, converter and linear references follow the node.
// - Power-good released only after every output clears its under-voltage level, or by voltage-select code 11111.
// - Fault latch disables outputs and switching, but not the core over-voltage lower switch, and drives the fault pin high.
// - Core or I/O over-voltage sets the fault latch immediately.
// - Third counted over-current sets the fault latch.
// - Linear under-voltage is blanked until the soft-start node is charged.
// - Only a bias supply power cycle clears counter and fault latch.
// - Core over-voltage sets latch and turns the lower switch on.
// - Bias between 4 V and reset level: lower switch clamps core above 1.26 V.
// - Linear regulator signals over-current above 230 mA.
// - Over-current trip inhibits outputs, discharges node, increments counter.
// - Later trips keep charging to 4 V before discharge and count.
// - Each converter over-current comparator counts only while its upper drive is on.
// - Core and linear over-currents are treated like the I/O one.
// - No converter switching until the node passes the ramp valley.
// - Soft-start node held low externally turns all regulators off.
// - Voltage-select code 11111 shuts down and leaves power-good open.
`timescale 1ns/1ps
`include "pfs_regs.svh"
module pfs_power_fault_sequencer #(
  parameter int SS_STEP_CYC = `PFS_SS_STEP_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // AXI4-Lite register port
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Comparator flags and pins, asynchronous
  input  wire logic        bias_por_ok,
  input  wire logic        supply5_por_ok,
  input  wire logic        bias_above_4v,
  input  wire logic        core_sense_ov,
  input  wire logic        io_sense_ov,
  input  wire logic        core_sense_above_126,
  input  wire logic        core_oc_trip,
  input  wire logic        io_oc_trip,
  input  wire logic        lin_oc_trip,
  input  wire logic        linear_undervolt_flag,
  input  wire logic        ss_held_low,
  input  wire logic [3:0]  out_above_uv,
  input  wire logic [4:0]  voltage_select_code,
  // Upper-switch drive from the converter logic, same clock
  input  wire logic        core_upper_drive,
  input  wire logic        io_upper_drive,
  // Soft-start node control
  output logic [7:0]       ss_level,
  output logic             ss_fast_charge,
  output logic             ss_charge,
  output logic             ss_discharge,
  output logic             soft_start_clamp,
  // Converter and switch control
  output logic             outputs_en,
  output logic             pwm_switch_en,
  output logic             lower_switch_on,
  // Pins
  output logic             fault_freq_pin_out,
  output logic             fault_freq_pin_oe,
  output logic             core_current_set_pin_oe,
  output logic             power_ok_oe
);

  localparam int NSYNC = 20;
  localparam logic [7:0] STEP_LAST = 8'(SS_STEP_CYC - 1);

  pfs_pkg::pfs_state_type state;
  pfs_pkg::pfs_state_type next_state;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [7:0]       next_level;
  logic [1:0]       oc_count;
  logic [1:0]       next_count;
  logic             fault_latch;
  logic             next_fault;
  logic [7:0]       div_cnt;
  logic [31:0]      ctrl;
  logic             aw_hold;
  logic             w_hold;
  logic [11:0]      aw_addr_q;
  logic [31:0]      w_data_q;
  logic [3:0]       w_strb_q;

  // Two-stage synchroniser for every pin-side flag
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {voltage_select_code, out_above_uv, ss_held_low, linear_undervolt_flag,
                lin_oc_trip, io_oc_trip, core_oc_trip, core_sense_above_126,
                io_sense_ov, core_sense_ov, bias_above_4v, supply5_por_ok, bias_por_ok};
      sync2 <= sync1;
    end

  // Named views of the synchronised flags
  wire       bias_ok   = sync2[0];
  wire       s5_ok     = sync2[1];
  wire       bias4     = sync2[2];
  wire       core_ov   = sync2[3];
  wire       io_ov     = sync2[4];
  wire       core126   = sync2[5];
  wire       core_oc   = sync2[6];
  wire       io_oc     = sync2[7];
  wire       lin_oc    = sync2[8]; // 230 mA comparator
  wire       lin_uv    = sync2[9];
  wire       held_low  = sync2[10];
  wire [3:0] uv_ok     = sync2[14:11];
  wire [4:0] vsel      = sync2[19:15];

  // Event decoding
  wire       tick       = (div_cnt == STEP_LAST);
  wire       ss_charged = (ss_level == `PFS_SS_FULL_LVL);
  wire       inhibit    = (vsel == `PFS_INHIBIT_CODE);
  wire       shut       = held_low | inhibit | ctrl[`PFS_CTRL_SHDN_BIT];
  wire       ov_any     = core_ov | io_ov;
  wire       pwm_oc     = (core_oc & core_upper_drive) | (io_oc & io_upper_drive);
  wire       uv_gated   = lin_uv & ss_charged;
  wire       oc_event   = pwm_oc | lin_oc | uv_gated;
  wire [7:0] level_up   = ss_level + 8'h01;
  wire [7:0] level_dn   = ss_level - 8'h01;
  wire [1:0] count_up   = oc_count + 2'h1;
  wire       sup_active = (state == pfs_pkg::PFS_CHARGE) || (state == pfs_pkg::PFS_RUN);
  wire       pg_good    = (&uv_ok) && (state == pfs_pkg::PFS_RUN);

  // Divider: one enable pulse per soft-start step
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      div_cnt <= 8'h00;
    else
      div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;

  // Sequencer next state; bias loss overrides all, then the latch
  always_comb
  begin
    next_state = state;
    next_level = ss_level;
    next_count = oc_count;
    next_fault = fault_latch;
    if (!bias_ok)
    begin
      next_state = pfs_pkg::PFS_OFF;
      next_level = `PFS_SS_ZERO_LVL;
      next_count = 2'h0;
      next_fault = 1'b0;
    end
    else if (fault_latch)
      next_state = pfs_pkg::PFS_FAULT;
    else if (ov_any)
    begin
      next_fault = 1'b1;
      next_state = pfs_pkg::PFS_FAULT;
    end
    else if (shut)
    begin
      next_state = pfs_pkg::PFS_OFF;
      next_level = `PFS_SS_ZERO_LVL;
    end
    else
      unique case (state)
        pfs_pkg::PFS_OFF:
          if (s5_ok)
            next_state = pfs_pkg::PFS_FAST;
        pfs_pkg::PFS_FAST:
        begin
          next_level = `PFS_SS_FAST_LVL;
          next_state = pfs_pkg::PFS_CHARGE;
        end
        pfs_pkg::PFS_CHARGE, pfs_pkg::PFS_RUN:
          if (oc_event)
          begin
            if (oc_count == 2'h0)
            begin
              next_count = count_up;
              next_state = pfs_pkg::PFS_DISCHARGE;
            end
            else
              next_state = pfs_pkg::PFS_OC_CHARGE;
          end
          else if (tick && !ss_charged)
          begin
            next_level = level_up;
            if (level_up == `PFS_SS_FULL_LVL)
              next_state = pfs_pkg::PFS_RUN;
          end
        pfs_pkg::PFS_OC_CHARGE:
          if (ss_charged)
          begin
            next_count = count_up;
            if (count_up == `PFS_OC_LIMIT)
            begin
              next_fault = 1'b1;
              next_state = pfs_pkg::PFS_FAULT;
            end
            else
              next_state = pfs_pkg::PFS_DISCHARGE;
          end
          else if (tick)
            next_level = level_up;
        pfs_pkg::PFS_DISCHARGE:
          if (tick)
          begin
            if (ss_level == `PFS_SS_ZERO_LVL)
              next_state = pfs_pkg::PFS_FAST; // Retry with a fresh soft-start
            else
              next_level = level_dn;
          end
        pfs_pkg::PFS_FAULT:
          next_state = pfs_pkg::PFS_FAULT;
        default:
          next_state = pfs_pkg::PFS_OFF;
      endcase
  end

  // Sequencer state, node level, retry counter and fault latch
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      state       <= pfs_pkg::PFS_OFF;
      ss_level    <= `PFS_SS_ZERO_LVL;
      oc_count    <= 2'h0;
      fault_latch <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      ss_level    <= next_level;
      oc_count    <= next_count;
      fault_latch <= next_fault;
    end

  // Registered outputs; a one-cycle lag behind the state is harmless at these rates
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      ss_fast_charge          <= 1'b0;
      ss_charge               <= 1'b0;
      ss_discharge            <= 1'b0;
      soft_start_clamp        <= 1'b0;
      outputs_en              <= 1'b0;
      pwm_switch_en           <= 1'b0;
      lower_switch_on         <= 1'b0;
      fault_freq_pin_out      <= 1'b0;
      fault_freq_pin_oe       <= 1'b0;
      core_current_set_pin_oe <= 1'b0;
      power_ok_oe             <= 1'b0;
    end
    else
    begin
      ss_fast_charge          <= (state == pfs_pkg::PFS_FAST);
      ss_charge               <= (state == pfs_pkg::PFS_CHARGE)
                                 || (state == pfs_pkg::PFS_OC_CHARGE);
      ss_discharge            <= (state == pfs_pkg::PFS_DISCHARGE);
      soft_start_clamp        <= (state == pfs_pkg::PFS_CHARGE);
      outputs_en              <= sup_active && !fault_latch;
      pwm_switch_en           <= sup_active && !fault_latch
                                 && (ss_level > `PFS_SS_VALLEY_LVL);
      lower_switch_on         <= (bias_ok && core_ov)
                                 || (!bias_ok && bias4 && core126);
      fault_freq_pin_out      <= fault_latch;
      fault_freq_pin_oe       <= fault_latch;
      core_current_set_pin_oe <= fault_latch;
      power_ok_oe             <= !pg_good && !inhibit;
    end

  // Register decode
  wire        wr_ctrl = ((aw_addr_q & `PFS_ADDR_MASK) == `PFS_CONTROL_OFF);
  wire [11:0] rd_addr = s_axi_araddr & `PFS_ADDR_MASK;
  wire        rd_stat = (rd_addr == `PFS_STATUS_OFF);
  wire        rd_ctrl = (rd_addr == `PFS_CONTROL_OFF);
  wire [31:0] status  = {13'h0000, pwm_switch_en, !power_ok_oe, fault_latch, 2'h0,
                         oc_count, 1'b0, state, ss_level};
  wire        wr_go   = aw_hold && w_hold && !s_axi_bvalid;

  // AXI4-Lite write: address and data taken in either order, one write at a time
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr_q     <= 12'h000;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PFS_RESP_OKAY;
      ctrl          <= `PFS_CONTROL_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold       <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold       <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ctrl ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
        if (wr_ctrl && w_strb_q[0])
          ctrl[7:0] <= w_data_q[7:0]; // Only the low byte holds control bits
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_hold       <= 1'b0;
        w_hold        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end

  // AXI4-Lite read: answer one cycle after the address is taken
  always_ff @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PFS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_stat ? status : (rd_ctrl ? ctrl : 32'h0000_0000);
      s_axi_rresp   <= (rd_stat || rd_ctrl) ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end

  // Checks on the sequencer
  sequence s_trip_discharge;
    state == pfs_pkg::PFS_DISCHARGE ##1 !outputs_en;
  endsequence
  sequence s_fast_step;
    ss_level == `PFS_SS_FAST_LVL && state == pfs_pkg::PFS_CHARGE;
  endsequence

  property p_por_gate;
    @(posedge ref_clk) disable iff (sys_rst)
      (state == pfs_pkg::PFS_OFF && !(bias_ok && s5_ok)) |=> state != pfs_pkg::PFS_FAST;
  endproperty
  a_por_gate: assert property (p_por_gate)
    else $error("soft-start began before reset");

  property p_fast_step;
    @(posedge ref_clk) disable iff (sys_rst)
      (state == pfs_pkg::PFS_FAST && bias_ok && !fault_latch && !ov_any && !shut)
      |=> s_fast_step;
  endproperty
  a_fast_step: assert property (p_fast_step)
    else $error("node did not jump to 1 V");

  property p_power_ok_out;
    @(posedge ref_clk) disable iff (sys_rst)
      !power_ok_oe && !$past(inhibit) && !$past(sys_rst) |-> $past(&uv_ok);
  endproperty
  a_power_ok_out: assert property (p_power_ok_out) else $error("power-good released too early");

  property p_fault_pins;
    @(posedge ref_clk) disable iff (sys_rst)
      fault_latch |=> fault_freq_pin_out && fault_freq_pin_oe && !outputs_en;
  endproperty
  a_fault_pins: assert property (p_fault_pins)
    else $error("fault latch did not shut down");

  property p_ov_latch;
    @(posedge ref_clk) disable iff (sys_rst)
      (ov_any && bias_ok) |=> fault_latch ##1 fault_freq_pin_oe;
  endproperty
  a_ov_latch: assert property (p_ov_latch)
    else $error("over-voltage missed the latch");

  property p_third_trip;
    @(posedge ref_clk) disable iff (sys_rst)
      (state == pfs_pkg::PFS_OC_CHARGE && ss_charged && oc_count == 2'h2 && bias_ok
       && !fault_latch && !ov_any && !shut) |=> fault_latch && oc_count == 2'h3;
  endproperty
  a_third_trip: assert property (p_third_trip)
    else $error("third trip did not latch");

  property p_lin_uv_blank;
    @(posedge ref_clk) disable iff (sys_rst)
      (state == pfs_pkg::PFS_CHARGE && !ss_charged && !pwm_oc && !lin_oc)
      |=> state != pfs_pkg::PFS_DISCHARGE && state != pfs_pkg::PFS_OC_CHARGE;
  endproperty
  a_lin_uv_blank: assert property (p_lin_uv_blank)
    else $error("blanked under-voltage tripped");

  property p_latch_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      (fault_latch && bias_ok) |=> fault_latch && $stable(oc_count);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("fault latch cleared by bias");

  property p_first_trip;
    @(posedge ref_clk) disable iff (sys_rst)
      (sup_active && oc_event && oc_count == 2'h0 && bias_ok && !fault_latch && !ov_any
       && !shut) |=> s_trip_discharge;
  endproperty
  a_first_trip: assert property (p_first_trip)
    else $error("first trip not inhibited");

  property p_valley;
    @(posedge ref_clk) disable iff (sys_rst)
      pwm_switch_en |-> $past(ss_level) > `PFS_SS_VALLEY_LVL;
  endproperty
  a_valley: assert property (p_valley) else $error("switching below ramp valley");

endmodule : pfs_power_fault_sequencer

// ===== bench/pfs_supply_model.sv
`timescale 1ns/1ps
`include "pfs_regs.svh"
module pfs_supply_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Scenario knobs from the bench
  input  wire logic [1:0] bias_lvl,
  input  wire logic       s5_on,
  input  wire logic       drive_block,
  input  wire logic [2:0] overload,
  input  wire logic [3:0] uv_low_mask,
  input  wire logic       hold_ss,
  // Block outputs seen by switches and load
  input  wire logic       outputs_en,
  input  wire logic       pwm_switch_en,
  input  wire logic [7:0] ss_level,
  // Supplies, drives and load comparators
  output logic            bias_por_ok,
  output logic            bias_above_4v,
  output logic            supply5_por_ok,
  output logic            core_upper_drive,
  output logic            io_upper_drive,
  output logic            core_oc_trip,
  output logic            io_oc_trip,
  output logic            lin_oc_trip,
  output logic            ss_held_low,
  output logic [3:0]      out_above_uv
);
  logic [1:0] drv_cnt;
  // Level 1 is the window between about 4 V and the reset threshold
  assign bias_above_4v  = (bias_lvl != 2'h0);
  assign bias_por_ok    = (bias_lvl == 2'h2);
  assign supply5_por_ok = s5_on;
  // Open-drain pull on the node from outside
  assign ss_held_low = hold_ss;
  // Upper drives pulse only while switching is allowed; the block can mask them
  assign core_upper_drive = drv_cnt[1] & ~drive_block;
  assign io_upper_drive   = drv_cnt[0] & ~drive_block;
  // A shorted load stays shorted, so trips are steady levels, not pulses
  assign core_oc_trip = overload[0];
  assign io_oc_trip   = overload[1];
  assign lin_oc_trip  = overload[2];
  // Outputs clear their under-voltage level only once the node is full
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      drv_cnt      <= 2'h0;
      out_above_uv <= 4'h0;
    end
    else
    begin
      drv_cnt      <= pwm_switch_en ? drv_cnt + 2'h1 : 2'h0;
      out_above_uv <= (outputs_en && ss_level == `PFS_SS_FULL_LVL) ? ~uv_low_mask : 4'h0;
    end
  end
endmodule : pfs_supply_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`include "pfs_regs.svh"
module tb_top;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0]  resp;
  } pfs_note_type;
  localparam int STEP = 2;
  localparam logic [11:0] ST = `PFS_STATUS_OFF;
  localparam logic [11:0] CT = `PFS_CONTROL_OFF;
  localparam logic [1:0]  OK = `PFS_RESP_OKAY;
  // Bench-driven inputs, all valued at time zero
  logic ref_clk = 1'b0, sys_rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic core_sense_ov = 1'b0, io_sense_ov = 1'b0, core_sense_above_126 = 1'b0;
  logic linear_undervolt_flag = 1'b0, s5_on = 1'b0, drive_block = 1'b0, hold_ss = 1'b0;
  logic [4:0] voltage_select_code = 5'h0c;
  logic [1:0] bias_lvl = 2'h0;
  logic [2:0] overload = 3'h0;
  logic [3:0] uv_low_mask = 4'h0;
  // Partner and design outputs
  logic bias_por_ok, bias_above_4v, supply5_por_ok, core_upper_drive, io_upper_drive;
  logic core_oc_trip, io_oc_trip, lin_oc_trip, ss_held_low;
  logic [3:0] out_above_uv;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] ss_level;
  logic ss_fast_charge, ss_charge, ss_discharge, soft_start_clamp, outputs_en;
  logic pwm_switch_en, lower_switch_on, fault_freq_pin_out, fault_freq_pin_oe;
  logic core_current_set_pin_oe, power_ok_oe;
  int mismatches = 0, checked = 0, seed = 65032, i, n;
  logic [31:0] rnd;
  pfs_note_type notes[$];
  pfs_note_type note;

  pfs_power_fault_sequencer #(.SS_STEP_CYC(STEP)) dut (
    .ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .bias_por_ok, .supply5_por_ok, .bias_above_4v, .core_sense_ov, .io_sense_ov,
    .core_sense_above_126, .core_oc_trip, .io_oc_trip, .lin_oc_trip, .linear_undervolt_flag,
    .ss_held_low, .out_above_uv, .voltage_select_code, .core_upper_drive, .io_upper_drive,
    .ss_level, .ss_fast_charge, .ss_charge, .ss_discharge, .soft_start_clamp, .outputs_en,
    .pwm_switch_en, .lower_switch_on, .fault_freq_pin_out, .fault_freq_pin_oe,
    .core_current_set_pin_oe, .power_ok_oe);

  pfs_supply_model supply (
    .ref_clk, .sys_rst, .bias_lvl, .s5_on, .drive_block, .overload, .uv_low_mask, .hold_ss,
    .outputs_en, .pwm_switch_en, .ss_level, .bias_por_ok, .bias_above_4v, .supply5_por_ok,
    .core_upper_drive, .io_upper_drive, .core_oc_trip, .io_oc_trip, .lin_oc_trip,
    .ss_held_low, .out_above_uv);

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic settle(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : settle

  // Address and data offered together; each dropped when its own ready is seen
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(r));
    @(posedge ref_clk);
  endtask : axi_write

  // The expected word is noted first; the watcher below compares it
  task automatic axi_read(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                          input logic [1:0] r);
    notes.push_back('{d, m, r});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_read

  // Read watcher: oldest note against each returned word
  always @(posedge ref_clk)
  begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
    begin
      note = notes.pop_front();
      check(s_axi_rdata & note.mask, note.data);
      check(32'(s_axi_rresp), 32'(note.resp));
    end
  end

  // Bounded wait for a node level; a miss shows up as a mismatch
  task automatic wait_lvl(input logic [7:0] l);
    int k;
    for (k = 0; k < 4000 && ss_level !== l; k++)
      @(posedge ref_clk);
    check(32'(ss_level), 32'(l));
  endtask : wait_lvl

  task automatic wait_run;
    wait_lvl(`PFS_SS_FAST_LVL);
    check(32'(ss_fast_charge), 32'h1);
    wait_lvl(8'h21);
    check(32'(pwm_switch_en), 32'h0);
    check(32'(ss_charge & soft_start_clamp), 32'h1);
    wait_lvl(`PFS_SS_FULL_LVL);
    settle(4);
    check(32'({pwm_switch_en, outputs_en}), 32'h3);
  endtask : wait_run

  // Bias power cycle with a fresh legal code; even values never hit inhibit
  task automatic power_up;
    bias_lvl <= 2'h0;
    settle(8);
    voltage_select_code <= 5'($random(seed)) & 5'h1e;
    bias_lvl <= 2'h2;
    wait_run;
  endtask : power_up

  initial
  begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    axi_read(CT, `PFS_CONTROL_RST, 32'hffff_ffff, OK);
    axi_read(ST, 32'h0, 32'h0007_37ff, OK);
    rnd = $random(seed) & 32'hffff_fffe;
    axi_write(CT, rnd, OK);
    axi_read(CT, rnd & 32'hff, 32'hff, OK);
    axi_write(12'h010, 32'hffff_ffff, `PFS_RESP_SLVERR);
    axi_read(12'h010, 32'h0, 32'hffff_ffff, `PFS_RESP_SLVERR);
    // A write without byte lane 0 must leave the control bits alone
    s_axi_wstrb <= 4'he;
    axi_write(CT, 32'h0, OK);
    s_axi_wstrb <= 4'hf;
    axi_read(CT, rnd & 32'hff, 32'hff, OK);
    axi_write(CT, 32'h0, OK);
    // Bias between about 4 V and reset: only the core clamp acts
    bias_lvl <= 2'h1;
    core_sense_above_126 <= 1'b1;
    settle(8);
    check(32'(lower_switch_on), 32'h1);
    core_sense_above_126 <= 1'b0;
    bias_lvl <= 2'h2;
    settle(20);
    check(32'({ss_level, outputs_en, lower_switch_on}), 32'h0);
    uv_low_mask <= 4'h4;
    s5_on <= 1'b1;
    wait_run;
    settle(8);
    check(32'(power_ok_oe), 32'h1);
    uv_low_mask <= 4'h0;
    settle(8);
    check(32'(power_ok_oe), 32'h0);
    axi_read(ST, 32'h0006_0380, 32'h0007_37ff, OK);
    voltage_select_code <= `PFS_INHIBIT_CODE;
    settle(8);
    check(32'({outputs_en, power_ok_oe}), 32'h0);
    voltage_select_code <= 5'h0c;
    wait_run;
    hold_ss <= 1'b1;
    settle(8);
    check(32'({ss_level, outputs_en}), 32'h0);
    // Linear under-voltage during the ramp must be blanked, then counted
    hold_ss <= 1'b0;
    linear_undervolt_flag <= 1'b1;
    wait_lvl(8'h70);
    linear_undervolt_flag <= 1'b0;
    wait_lvl(`PFS_SS_FULL_LVL);
    settle(4);
    axi_read(ST, 32'h0000_0380, 32'h0000_37ff, OK);
    linear_undervolt_flag <= 1'b1;
    wait_lvl(8'h7f);
    check(32'({ss_discharge, outputs_en}), 32'h2);
    linear_undervolt_flag <= 1'b0;
    // Steady overload on core, I/O and linear in turn
    for (i = 0; i < 3; i++)
    begin
      power_up;
      axi_read(ST, 32'h0000_0300, 32'h0001_3700, OK);
      drive_block <= 1'b1;
      overload <= 3'(1 << i);
      settle(20);
      check(32'(ss_discharge), 32'(i == 2));
      drive_block <= 1'b0;
      wait_lvl(8'h00);
      wait_lvl(`PFS_SS_FULL_LVL);
      for (n = 0; n < 8000 && fault_freq_pin_oe !== 1'b1; n++)
        @(posedge ref_clk);
      check(32'({fault_freq_pin_out, fault_freq_pin_oe, core_current_set_pin_oe, outputs_en}),
            32'he);
      axi_read(ST, 32'h0001_3600, 32'h0001_3700, OK);
      core_sense_ov <= 1'b1;
      settle(40);
      axi_read(ST, 32'h0001_3600, 32'h0001_3700, OK);
      core_sense_ov <= 1'b0;
      overload <= 3'h0;
    end
    // Over-voltage latches at once, without counting
    for (i = 0; i < 2; i++)
    begin
      power_up;
      {io_sense_ov, core_sense_ov} <= 2'(1 << i);
      settle(8);
      check(32'({fault_freq_pin_oe, lower_switch_on}), 32'(3 - i));
      axi_read(ST, 32'h0001_0600, 32'h0001_3700, OK);
      {io_sense_ov, core_sense_ov} <= 2'h0;
    end
    power_up;
    axi_read(ST, 32'h0000_0300, 32'h0001_3700, OK);
    complete_run;
  end

  // Watchdog: the full run needs well under this span
  initial
  begin
    #400000;
    mismatches++;
    complete_run;
  end
endmodule : tb_top
